// ===== rtl/lisf_top.sv
// Local interrupt request logic: select register, three groups, local output plus enable-gated host output
`timescale 1ns/10ps
`include "lisf_params.svh"
module lisf_top (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    reg_sel,
	input  wire logic                    reg_wr,
	input  wire logic [`LISF_ADDR_W-1:0] reg_addr,
	input  wire lisf_pkg::lisf_word_t    reg_wdata,
	output lisf_pkg::lisf_word_t         reg_rdata_r,
	input  wire logic                    init_done,
	input  wire logic                    autocal_done,
	input  wire logic                    aux_in,
	input  wire logic                    in_threshold,
	input  wire logic                    out_threshold,
	input  wire logic                    out_burst_done,
	input  wire logic                    host_int_en,
	input  wire logic                    local_int_en,
	output logic                         local_irq_r,
	output logic                         host_irq_r
);
	import lisf_pkg::*;

	lisf_sel_t   g0_sel_r;
	lisf_sel_t   g1_sel_r;
	lisf_sel_t   g2_sel_r;
	logic        g0_flag;
	logic        g1_flag;
	logic        g2_flag;
	logic        g0_clear;
	logic        g1_clear;
	logic        g2_clear;
	logic        any_flag;
	logic        wr_hit;
	logic        init_d_r;
	logic        init_pulse;
	lisf_word_t  reg_view;

	// Write strobe for this register; writes to other offsets fall through
	assign wr_hit = reg_sel && reg_wr && (reg_addr == `LISF_REG_OFFSET);

	// A zero in a flag bit withdraws that request; a one leaves the flag alone
	assign g0_clear = wr_hit && !reg_wdata[`LISF_G0_FLAG_BIT];
	assign g1_clear = wr_hit && !reg_wdata[`LISF_G1_FLAG_BIT];
	assign g2_clear = wr_hit && !reg_wdata[`LISF_G2_FLAG_BIT];

	// Condition select fields, idle after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			g0_sel_r <= `LISF_SEL_IDLE;
			g1_sel_r <= `LISF_SEL_IDLE;
			g2_sel_r <= `LISF_SEL_IDLE;
		end else if (wr_hit) begin
			g0_sel_r <= reg_wdata[`LISF_G0_SEL_LSB +: `LISF_SEL_W];
			g1_sel_r <= reg_wdata[`LISF_G1_SEL_LSB +: `LISF_SEL_W];
			g2_sel_r <= reg_wdata[`LISF_G2_SEL_LSB +: `LISF_SEL_W];
		end
	end

	// Init completion edge; the flag also starts high since reset is init
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_d_r <= 1'b0;
		end else begin
			init_d_r <= init_done;
		end
	end
	assign init_pulse = init_done && !init_d_r;

	// Group 0 flag comes up high at reset, so its own reset flop is separate
	logic g0_boot_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			g0_boot_r <= 1'b1;
		end else if (g0_clear) begin
			g0_boot_r <= 1'b0;
		end
	end

	logic g0_ev_flag;
	lisf_group #(.NCOND(3)) u_g0 (
		.clk       (clk),
		.rst_n     (rst_n),
		.cond      ({!aux_in, aux_in, autocal_done}),
		.sel       (g0_sel_r),
		.force_set (init_pulse),
		.clear     (g0_clear),
		.flag_r    (g0_ev_flag)
	);
	assign g0_flag = g0_ev_flag || g0_boot_r;

	lisf_group #(.NCOND(2)) u_g1 (
		.clk       (clk),
		.rst_n     (rst_n),
		.cond      ({!in_threshold, in_threshold}),
		.sel       (g1_sel_r),
		.force_set (1'b0),
		.clear     (g1_clear),
		.flag_r    (g1_flag)
	);

	lisf_group #(.NCOND(3)) u_g2 (
		.clk       (clk),
		.rst_n     (rst_n),
		.cond      ({out_burst_done, !out_threshold, out_threshold}),
		.sel       (g2_sel_r),
		.force_set (1'b0),
		.clear     (g2_clear),
		.flag_r    (g2_flag)
	);

	// Register image; bits above the group 2 flag read zero
	always_comb begin
		reg_view = '0;
		reg_view[`LISF_G0_SEL_LSB +: `LISF_SEL_W] = g0_sel_r;
		reg_view[`LISF_G0_FLAG_BIT]               = g0_flag;
		reg_view[`LISF_G1_SEL_LSB +: `LISF_SEL_W] = g1_sel_r;
		reg_view[`LISF_G1_FLAG_BIT]               = g1_flag;
		reg_view[`LISF_G2_SEL_LSB +: `LISF_SEL_W] = g2_sel_r;
		reg_view[`LISF_G2_FLAG_BIT]               = g2_flag;
	end

	// Registered read data; unmapped offsets read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= `LISF_RESET_VALUE;
		end else if (reg_addr == `LISF_REG_OFFSET) begin
			reg_rdata_r <= reg_view;
		end else begin
			reg_rdata_r <= '0;
		end
	end

	// One OR feeds both request lines; only the host line is gated by the enables
	assign any_flag = g0_flag || g1_flag || g2_flag;

	// Local request line, one cycle behind the flags; high at reset with group 0
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			local_irq_r <= 1'b1;
		end else begin
			local_irq_r <= any_flag;
		end
	end

	// Host line gated by both bridge enables; the gate is not latched,
	// so dropping either enable withdraws the line at the next edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_irq_r <= 1'b0;
		end else begin
			host_irq_r <= any_flag && host_int_en && local_int_en;
		end
	end

	// Host line follows the flags only through both bridge enables
	a_host_gate: assert property (@(posedge clk) disable iff (!rst_n)
		host_irq_r |-> $past(host_int_en) && $past(local_int_en))
		else $error("host request without both enables");
	a_host_exact: assert property (@(posedge clk) disable iff (!rst_n)
		host_irq_r == ($past(any_flag) && $past(host_int_en) && $past(local_int_en)))
		else $error("host line does not follow gated flags");

	// Local line is the OR of the three flags, one cycle late
	a_or_tracks: assert property (@(posedge clk) disable iff (!rst_n)
		(g1_flag || g2_flag) |=> local_irq_r)
		else $error("local line missed a flag");
	a_local_exact: assert property (@(posedge clk) disable iff (!rst_n)
		local_irq_r == $past(any_flag))
		else $error("local line does not follow flags");

	// End of initialization raises group 0 whatever its select
	a_init_raise: assert property (@(posedge clk) disable iff (!rst_n)
		init_pulse |=> g0_flag ##1 local_irq_r)
		else $error("init did not raise group 0");

	// Inactive bits never read back as one
	a_high_zero: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rdata_r[31:`LISF_G2_FLAG_BIT + 1] == '0)
		else $error("inactive bits nonzero");

	// A zero written to a flag clears it unless its event lands in that cycle
	a_write_clears: assert property (@(posedge clk) disable iff (!rst_n)
		g1_clear
		&& !(in_threshold && !u_g1.cond_d_r[0] && g1_sel_r == `LISF_SEL_1)
		&& !(!in_threshold && !u_g1.cond_d_r[1] && g1_sel_r == `LISF_SEL_2)
		|=> !g1_flag)
		else $error("group 1 flag not cleared");
	a_g0_clears: assert property (@(posedge clk) disable iff (!rst_n)
		g0_clear && !init_pulse && !u_g0.event_nxt |=> !g0_flag)
		else $error("group 0 flag not cleared");
	a_g2_clears: assert property (@(posedge clk) disable iff (!rst_n)
		g2_clear && !u_g2.event_nxt |=> !g2_flag)
		else $error("group 2 flag not cleared");

	// The reset-time request, once withdrawn, returns only through reset
	a_boot_stays: assert property (@(posedge clk) disable iff (!rst_n)
		!g0_boot_r |=> !g0_boot_r)
		else $error("reset request came back");

	// Select fields take the written value
	a_sel_store: assert property (@(posedge clk) disable iff (!rst_n)
		wr_hit |=> g2_sel_r == $past(reg_wdata[`LISF_G2_SEL_LSB +: `LISF_SEL_W]))
		else $error("select not stored");
	a_sel_g0: assert property (@(posedge clk) disable iff (!rst_n)
		wr_hit |=> g0_sel_r == $past(reg_wdata[`LISF_G0_SEL_LSB +: `LISF_SEL_W]))
		else $error("group 0 select not stored");
	a_sel_g1: assert property (@(posedge clk) disable iff (!rst_n)
		wr_hit |=> g1_sel_r == $past(reg_wdata[`LISF_G1_SEL_LSB +: `LISF_SEL_W]))
		else $error("group 1 select not stored");

	// Main scenarios worth seeing at least once
	c_host_irq: cover property (@(posedge clk) disable iff (!rst_n) host_irq_r);
	c_clear_g0: cover property (@(posedge clk) disable iff (!rst_n) g0_flag ##1 !g0_flag);
	c_burst: cover property (@(posedge clk) disable iff (!rst_n)
		g2_sel_r == `LISF_SEL_3 ##1 g2_flag);
endmodule : lisf_top

// ===== rtl/lisf_params.svh
// Constants for the local interrupt select and flag register
`ifndef LISF_PARAMS_SVH
`define LISF_PARAMS_SVH
`define LISF_ADDR_W        8
`define LISF_REG_OFFSET    8'h04
`define LISF_RESET_VALUE   32'h00000008
`define LISF_G0_SEL_LSB    0
`define LISF_G0_FLAG_BIT   3
`define LISF_G1_SEL_LSB    4
`define LISF_G1_FLAG_BIT   7
`define LISF_G2_SEL_LSB    8
`define LISF_G2_FLAG_BIT   11
`define LISF_SEL_W         3
`define LISF_SEL_IDLE      3'h0
`define LISF_SEL_1         3'h1
`define LISF_SEL_2         3'h2
`define LISF_SEL_3         3'h3
`endif

// ===== rtl/lisf_pkg.sv
// Types shared by the local interrupt select and flag logic
package lisf_pkg;
	typedef logic [2:0]  lisf_sel_t;
	typedef logic [31:0] lisf_word_t;
	typedef enum logic [1:0] {
		LISF_INIT = 2'h0,
		LISF_RUN  = 2'h1
	} lisf_state_t;
endpackage : lisf_pkg

// ===== rtl/lisf_group.sv
// One condition group: select decode, edge detect and sticky request flag
`timescale 1ns/10ps
`include "lisf_params.svh"
module lisf_group #(
	parameter int NCOND = 3
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [NCOND-1:0] cond,
	input  wire lisf_pkg::lisf_sel_t sel,
	input  wire logic             force_set,
	input  wire logic             clear,
	output logic                  flag_r
);
	import lisf_pkg::*;

	logic [NCOND-1:0] cond_d_r;
	logic [NCOND-1:0] hit;
	logic             event_nxt;

	// Previous condition levels, for false to true detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cond_d_r <= '0;
		end else begin
			cond_d_r <= cond;
		end
	end

	// Only a rising condition counts; a level already true when selected is ignored
	genvar i;
	generate
		for (i = 0; i < NCOND; i++) begin : g_cond
			assign hit[i] = cond[i] && !cond_d_r[i] && (sel == lisf_sel_t'(i + 1));
		end
	endgenerate

	// Idle and reserved codes match no entry above
	assign event_nxt = |hit;

	// Sticky flag; a set in the clearing cycle wins so no event is lost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_r <= 1'b0;
		end else if (event_nxt || force_set) begin
			flag_r <= 1'b1;
		end else if (clear) begin
			flag_r <= 1'b0;
		end
	end

	a_flag_sets: assert property (@(posedge clk) disable iff (!rst_n)
		event_nxt |=> flag_r) else $error("flag missed its event");
	a_flag_holds: assert property (@(posedge clk) disable iff (!rst_n)
		flag_r && !clear |=> flag_r) else $error("flag dropped without clear");
	a_no_spurious: assert property (@(posedge clk) disable iff (!rst_n)
		!flag_r && !event_nxt && !force_set |=> !flag_r)
		else $error("flag rose without event");
	a_reserved_idle: assert property (@(posedge clk) disable iff (!rst_n)
		(sel == '0 || sel > lisf_sel_t'(NCOND)) |-> !event_nxt)
		else $error("idle or reserved select raised an event");
	c_group_event: cover property (@(posedge clk) disable iff (!rst_n) event_nxt);
endmodule : lisf_group

// ===== test/lisf_bridge_model.sv
// Bridge model: holds the two host interrupt enables
`timescale 1ns/10ps
module lisf_bridge_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] en_req,
	output logic            host_int_en,
	output logic            local_int_en
);
	// Software sets both enables; reset leaves host traffic blocked
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_int_en  <= 1'b0;
			local_int_en <= 1'b0;
		end else begin
			host_int_en  <= en_req[1];
			local_int_en <= en_req[0];
		end
	end
endmodule : lisf_bridge_model

// ===== test/testbench.sv
// Self-checking bench for the local interrupt select and flag logic
`timescale 1ns/10ps
`include "lisf_params.svh"
module testbench;
	import lisf_pkg::*;
	logic       clk         = 1'b0;
	logic       rst_n       = 1'b0;
	logic       reg_sel     = 1'b0;
	logic       reg_wr      = 1'b0;
	lisf_word_t reg_wdata   = 32'h0;
	logic       init_done   = 1'b0;
	logic [4:0] cnd         = 5'h00;
	logic [1:0] en_req      = 2'h3;
	logic [7:0] reg_addr    = `LISF_REG_OFFSET;
	lisf_word_t reg_rdata_r;
	logic       host_int_en;
	logic       local_int_en;
	logic       local_irq_r;
	logic       host_irq_r;
	int         n_mismatch  = 0;
	int         checks_done = 0;
	always #5 clk = ~clk;
	// Read data tracks reg_addr every cycle, with no strobe needed
	lisf_top lisf_top_inst (.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
		.init_done(init_done), .autocal_done(cnd[0]), .aux_in(cnd[1]),
		.in_threshold(cnd[2]), .out_threshold(cnd[3]), .out_burst_done(cnd[4]),
		.host_int_en(host_int_en), .local_int_en(local_int_en),
		.local_irq_r(local_irq_r), .host_irq_r(host_irq_r));
	lisf_bridge_model lisf_bridge_model_inst (.clk(clk), .rst_n(rst_n), .en_req(en_req),
		.host_int_en(host_int_en), .local_int_en(local_int_en));
	task automatic chk(string what, lisf_word_t exp, lisf_word_t got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr(lisf_word_t d);
		@(posedge clk);
		reg_sel   <= 1'b1;
		reg_wr    <= 1'b1;
		reg_wdata <= d;
		@(posedge clk);
		reg_sel <= 1'b0;
		reg_wr  <= 1'b0;
		tick(2);
	endtask : wr
	// Sweep the four enable pairs with the reset request still pending
	task automatic enables_case;
		for (int e = 0; e < 4; e++) begin
			@(posedge clk);
			en_req <= e[1:0];
			tick(3);
			chk("host line", {31'h0, e == 3}, {31'h0, host_irq_r});
		end
	endtask : enables_case
	// Select, then edge the condition; the select write also clears flags
	task automatic sel_case(lisf_word_t s, int b, logic v, lisf_word_t f);
		@(posedge clk);
		cnd[b] <= !v;
		tick(2);
		wr(s);
		chk("select", s, reg_rdata_r);
		@(posedge clk);
		cnd[b] <= v;
		tick(3);
		chk("flags", s | f, reg_rdata_r);
		chk("local line", {31'h0, f != 0}, {31'h0, local_irq_r});
	endtask : sel_case
	// Ones into flags and high bits must not stick
	task automatic ones_case;
		wr(32'h0);
		wr(32'hFFFFF888);
		chk("ones write", 32'h0, reg_rdata_r);
	endtask : ones_case
	// Writes at another offset are ignored, and that offset reads zero
	task automatic offset_case;
		@(posedge clk);
		reg_addr <= 8'h08;
		wr(32'h111);
		chk("other offset", 32'h0, reg_rdata_r);
		@(posedge clk);
		reg_addr <= `LISF_REG_OFFSET;
		tick(2);
		chk("ignored write", 32'h0, reg_rdata_r);
	endtask : offset_case
	// Mid-run reset brings back the power-up word and request lines
	task automatic reset_case;
		@(posedge clk);
		rst_n     <= 1'b0;
		init_done <= 1'b0;
		tick(2);
		chk("reset local", 32'h1, {31'h0, local_irq_r});
		chk("reset host", 32'h0, {31'h0, host_irq_r});
		@(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		chk("reset word", 32'h00000008, reg_rdata_r);
		tick(1);
		chk("host line", 32'h1, {31'h0, host_irq_r});
	endtask : reset_case
	// Init end sets group 0 flag even when idle; only a zero write clears it
	task automatic init_case;
		@(posedge clk);
		init_done <= 1'b1;
		tick(3);
		chk("init flag", 32'h8, reg_rdata_r);
		chk("host line", 32'h1, {31'h0, host_irq_r});
		wr(32'h8);
		chk("kept flag", 32'h8, reg_rdata_r);
		wr(32'h0);
		chk("cleared", 32'h0, reg_rdata_r);
		chk("local off", 32'h0, {31'h0, local_irq_r});
	endtask : init_case
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	// Hang guard
	initial begin
		#200000;
		n_mismatch++;
		results();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		chk("reset word", 32'h00000008, reg_rdata_r);
		enables_case();
		sel_case(32'h001, 0, 1'b1, 32'h008);
		sel_case(32'h002, 1, 1'b1, 32'h008);
		sel_case(32'h003, 1, 1'b0, 32'h008);
		sel_case(32'h000, 0, 1'b1, 32'h000);
		sel_case(32'h001, 0, 1'b0, 32'h000);
		sel_case(32'h004, 1, 1'b1, 32'h000);
		sel_case(32'h010, 2, 1'b1, 32'h080);
		sel_case(32'h020, 2, 1'b0, 32'h080);
		sel_case(32'h030, 2, 1'b1, 32'h000);
		sel_case(32'h100, 3, 1'b1, 32'h800);
		sel_case(32'h200, 3, 1'b0, 32'h800);
		sel_case(32'h300, 4, 1'b1, 32'h800);
		sel_case(32'h400, 4, 1'b1, 32'h000);
		ones_case();
		offset_case();
		init_case();
		reset_case();
		results();
	end
endmodule : testbench
